/* verilog/mb_front_pkg.sv */
/*
 * Shared constants and types for the serial link framer front end.
 * Assumes a single 25 MHz system clock and a byte-wide UART on each side.
 */
package mb_front_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned SLEEP_TIME_S = 40;
   localparam int unsigned SLEEP_CYCLES = SLEEP_TIME_S * CLK_HZ;
   localparam int unsigned CHAR_CYCLES  = 28_646;     // one char, plain default
   localparam int unsigned REPLY_CYCLES = 25_000_000; // master reply timeout
   // ****************************************
   // framing constants
   // ****************************************
   localparam logic [7:0]  ADDR_MIN  = 8'h01;
   localparam logic [7:0]  ADDR_MAX  = 8'hF7;
   localparam logic [15:0] CRC_INIT  = 16'hFFFF;
   localparam logic [15:0] CRC_POLY  = 16'hA001;
   localparam logic [7:0]  ASC_COLON = 8'h3A;
   localparam logic [7:0]  ASC_CR    = 8'h0D;
   localparam logic [7:0]  ASC_LF    = 8'h0A;
   localparam logic [7:0]  ASC_0     = 8'h30;
   localparam logic [7:0]  ASC_9     = 8'h39;
   localparam logic [7:0]  ASC_A     = 8'h41;
   localparam logic [7:0]  ASC_F     = 8'h46;
   localparam logic [15:0] IDX_ADDR  = 16'h0000;
   localparam logic [15:0] IDX_FUNC  = 16'h0001;
   localparam logic [15:0] IDX_TFUNC = 16'h0007;
   localparam logic [15:0] IDX_TLENH = 16'h0004;
   localparam logic [15:0] IDX_TLENL = 16'h0005;
   localparam logic [15:0] TCP_HDR   = 16'h0006;
   localparam logic [7:0]  FC_RD_COIL  = 8'h01;
   localparam logic [7:0]  FC_RD_DIN   = 8'h02;
   localparam logic [7:0]  FC_RD_HOLD  = 8'h03;
   localparam logic [7:0]  FC_RD_INREG = 8'h04;
   localparam logic [7:0]  FC_WR_COIL  = 8'h05;
   localparam logic [7:0]  FC_WR_HOLD  = 8'h06;
   localparam logic [7:0]  FC_WR_COILS = 8'h0F;
   localparam logic [7:0]  FC_WR_HOLDS = 8'h10;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {V_RTU, V_ASCII, V_TCP} variant_t;
   typedef enum logic [1:0] {TB_COIL_RW, TB_COIL_RO, TB_REG_RO,
                             TB_REG_RW} table_t;
   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } beat_t;
   typedef struct packed {
      logic   good;
      logic   func_ok;
      table_t tbl;
   } rpt_t;
endpackage

/* verilog/mb_front.sv */
/*
 * Framer front end: receive deframing, transmit framing, port sleep.
 * Assumes byte-wide UART logic on SYS_CLK on both the receive and send side.
 */
// Functional notes
// - sleep after 40 s without activity
// - asleep: first packet wakes, gets discarded
// - always-on setting never sleeps
// - binary gap of 1.5 chars breaks message
// - binary frames end with cyclic check
// - ASCII hex characters with longitudinal check
// - TCP frames carry no checksum
// - IP links always use TCP framing
// - serial slave uses binary framing only
// - master picks ASCII or binary per transaction
// - master or slave role selectable
// - four tables, coils and registers, ro/rw
// - drive shared pair only while a frame is in progress, T_GET waits for the next body byte included; not while a master awaits its reply
// - frames start with address, function code; TCP frames put a 6-byte header first
// - one command at a time, master waits
// - serial slave answers only its address 1..247
// - supports standard read/write function codes
`timescale 1ns/10ps
module mb_front
   import mb_front_pkg::*;
#(
   parameter int unsigned CHAR_CYC  = CHAR_CYCLES,
   parameter int unsigned SLEEP_CNT = SLEEP_CYCLES,
   parameter int unsigned REPLY_CNT = REPLY_CYCLES
)(
   input  wire logic       SYS_CLK,
   input  wire logic       RSTN,
   input  wire logic       MASTER,
   input  wire logic       ASCII_SEL,
   input  wire logic       LINK_IP,
   input  wire logic       ALWAYS_ON,
   input  wire logic [7:0] SLAVE_ADDR,
   input  wire logic       RX_VALID,
   input  wire logic [7:0] RX_DATA,
   output logic            RX_READY,
   output logic            OUT_VALID,
   output beat_t           OUT_BEAT,
   input  wire logic       OUT_READY,
   output logic            FRAME_DONE,
   output rpt_t            FRAME_RPT,
   input  wire logic       TX_IN_VALID,
   input  wire logic [7:0] TX_IN_DATA,
   input  wire logic       TX_IN_LAST,
   output logic            TX_IN_READY,
   output logic            TX_VALID,
   output logic [7:0]      TX_DATA,
   input  wire logic       TX_READY,
   output logic            DRIVE_EN,
   output logic            ASLEEP,
   output logic            SLEEP_ENTER,
   output logic            AWAIT_REPLY
);
   localparam int unsigned SIL_W = $clog2(CHAR_CYC * 4);
   localparam int unsigned SLP_W = $clog2(SLEEP_CNT + 1);
   localparam int unsigned RPL_W = $clog2(REPLY_CNT + 1);
   localparam logic [SIL_W-1:0] G15 = SIL_W'((CHAR_CYC * 3 + 1) / 2);
   localparam logic [SIL_W-1:0] G35 = SIL_W'((CHAR_CYC * 7 + 1) / 2);
   localparam logic [SLP_W-1:0] SLP_LAST = SLP_W'(SLEEP_CNT - 1);
   localparam logic [RPL_W-1:0] RPL_LAST = RPL_W'(REPLY_CNT - 1);

   typedef enum logic [3:0] {T_IDLE, T_COLON, T_GET, T_BYTE, T_LO, T_CK_A,
                             T_CK_B, T_CR, T_LF} tx_st_t;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      return r;
   endfunction
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      if (c >= ASC_0 && c <= ASC_9)
         return {1'b1, 4'(c - ASC_0)};
      else if (c >= ASC_A && c <= ASC_F)
         return {1'b1, 4'(c - ASC_A + 8'h0A)};
      return 5'h00;
   endfunction
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? 8'(ASC_0 + n) : 8'(ASC_A + n - 8'h0A);
   endfunction
   // ip forces TCP, serial slave binary, master free choice
   function automatic variant_t pick(input logic ip, input logic m,
                                     input logic a);
      if (ip)
         return V_TCP;
      else if (!m)
         return V_RTU;
      return a ? V_ASCII : V_RTU;
   endfunction
   function automatic table_t tbl_of(input logic [7:0] f);
      case (f)
         FC_RD_DIN:   return TB_COIL_RO;
         FC_RD_INREG: return TB_REG_RO;
         FC_RD_HOLD, FC_WR_HOLD, FC_WR_HOLDS: return TB_REG_RW;
         default:     return TB_COIL_RW;
      endcase
   endfunction

   logic             in_frame, broken, addr_ok, half, wake_disc;
   logic             pending, awaiting, tlast, hs, got, start_ok, tx_end;
   logic [15:0]      cnt, crc, tlen, tcrc;
   logic [7:0]       lrc, func, hold, tlrc;
   logic [3:0]       nib;
   logic [SIL_W-1:0] sil;
   logic [SLP_W-1:0] idle;
   logic [RPL_W-1:0] rwait;
   variant_t         rvar, tvar;
   tx_st_t           tst;
   beat_t            buf0, buf1;
   logic [1:0]       bcnt;
   logic             next_in_frame, next_broken, next_addr_ok, next_half;
   logic             next_done, next_wake, next_pending, next_awaiting;
   logic             next_asleep, next_enter, next_tlast, push, disc;
   logic [15:0]      next_cnt, next_crc, next_tlen, next_tcrc;
   logic [7:0]       next_lrc, next_func, next_hold, next_tlrc, b;
   logic [3:0]       next_nib;
   logic [SIL_W-1:0] next_sil;
   logic [SLP_W-1:0] next_idle;
   logic [RPL_W-1:0] next_rwait;
   variant_t         next_tvar;
   tx_st_t           next_tst;
   rpt_t             next_rpt;
   beat_t            next_buf0, next_buf1;
   logic [1:0]       next_bcnt;
   logic             byte_ok, fin, chk;
   logic [4:0]       hv;

   assign got      = RX_VALID && RX_READY;
   assign hs       = TX_VALID && TX_READY;
   assign rvar     = pick(LINK_IP, MASTER, tvar == V_ASCII);
   // master waits for reply, slave only answers
   assign start_ok = MASTER ? !awaiting : pending;
   assign disc     = wake_disc || (got && ASLEEP) || (!MASTER && pending);

   // ****************************************
   // receive deframing
   // ****************************************
   always_comb
   begin
      next_in_frame = in_frame;
      next_broken   = broken;
      next_addr_ok  = addr_ok;
      next_half     = half;
      next_cnt      = cnt;
      next_crc      = crc;
      next_lrc      = lrc;
      next_func     = func;
      next_nib      = nib;
      next_tlen     = tlen;
      next_rpt      = FRAME_RPT;
      next_done     = 1'b0;
      byte_ok       = 1'b0;
      fin           = 1'b0;
      chk           = 1'b0;
      b             = RX_DATA;
      hv            = hex_val(RX_DATA);
      next_sil      = got ? '0 : ((sil == G35) ? sil : SIL_W'(sil + 1'b1));
      if (rvar == V_ASCII)
      begin
         if (got && RX_DATA == ASC_COLON)
         begin
            next_in_frame = 1'b1;
            next_broken   = 1'b0;
            next_half     = 1'b0;
            next_cnt      = '0;
            next_lrc      = '0;
         end
         else if (got && in_frame && RX_DATA == ASC_LF)
         begin
            fin = 1'b1;
            chk = (lrc == 8'h00) && !half;
         end
         else if (got && in_frame && RX_DATA != ASC_CR)
         begin
            next_broken = broken || !hv[4];
            next_half   = !half;
            next_nib    = hv[3:0];
            byte_ok     = half;
            b           = {nib, hv[3:0]};
         end
      end
      else if (got)
      begin
         byte_ok = 1'b1;
         if (!in_frame)
         begin
            next_in_frame = 1'b1;
            next_broken   = 1'b0;
            next_cnt      = '0;
            next_crc      = CRC_INIT;
         end
         else if (rvar == V_RTU && sil >= G15)
            next_broken = 1'b1;
      end
      else if (in_frame && rvar == V_RTU && sil == G35 - 1'b1)
      begin
         fin = 1'b1;
         chk = (crc == 16'h0000);
      end
      if (byte_ok)
      begin
         if (next_cnt == IDX_ADDR)
            next_addr_ok = b == SLAVE_ADDR && b >= ADDR_MIN
                           && b <= ADDR_MAX;
         if (next_cnt == ((rvar == V_TCP) ? IDX_TFUNC : IDX_FUNC))
            next_func = b;
         if (next_cnt == IDX_TLENH)
            next_tlen[15:8] = b;
         if (next_cnt == IDX_TLENL)
            next_tlen[7:0] = b;
         next_crc = crc_step(next_crc, b);
         next_lrc = 8'(next_lrc + b);
         next_cnt = 16'(next_cnt + 1'b1);
         if (rvar == V_TCP && next_cnt > TCP_HDR
             && next_cnt == 16'(next_tlen + TCP_HDR))
         begin
            fin = 1'b1;
            chk = 1'b1;
         end
      end
      push = byte_ok && !disc;
      if (fin)
      begin
         next_in_frame    = 1'b0;
         next_done        = 1'b1;
         next_rpt.good    = chk && !next_broken && !disc
                            && (MASTER || LINK_IP || next_addr_ok);
         next_rpt.tbl     = tbl_of(next_func);
         next_rpt.func_ok = next_func inside {FC_RD_COIL, FC_RD_DIN,
            FC_RD_HOLD, FC_RD_INREG, FC_WR_COIL, FC_WR_HOLD, FC_WR_COILS,
            FC_WR_HOLDS};
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         in_frame   <= 1'b0;
         broken     <= 1'b0;
         addr_ok    <= 1'b0;
         half       <= 1'b0;
         cnt        <= '0;
         crc        <= CRC_INIT;
         lrc        <= '0;
         func       <= '0;
         nib        <= '0;
         tlen       <= '0;
         sil        <= G35;
         FRAME_DONE <= 1'b0;
         FRAME_RPT  <= '0;
      end
      else
      begin
         in_frame   <= next_in_frame;
         broken     <= next_broken;
         addr_ok    <= next_addr_ok;
         half       <= next_half;
         cnt        <= next_cnt;
         crc        <= next_crc;
         lrc        <= next_lrc;
         func       <= next_func;
         nib        <= next_nib;
         tlen       <= next_tlen;
         sil        <= next_sil;
         FRAME_DONE <= next_done;
         FRAME_RPT  <= next_rpt;
      end
   end

   // ****************************************
   // transmit framing
   // ****************************************
   always_comb
   begin
      next_tst   = tst;
      next_tvar  = tvar;
      next_tcrc  = tcrc;
      next_tlrc  = tlrc;
      next_hold  = hold;
      next_tlast = tlast;
      tx_end     = 1'b0;
      case (tst)
         T_IDLE:
            if (start_ok && !in_frame)
            begin
               next_tvar = pick(LINK_IP, MASTER, ASCII_SEL);
               next_tcrc = CRC_INIT;
               next_tlrc = '0;
               next_tst  = (next_tvar == V_ASCII) ? T_COLON : T_GET;
            end
         T_COLON:
            if (hs)
               next_tst = T_GET;
         T_GET:
            if (TX_IN_VALID && TX_IN_READY)
            begin
               next_hold  = TX_IN_DATA;
               next_tlast = TX_IN_LAST;
               next_tcrc  = crc_step(tcrc, TX_IN_DATA);
               next_tlrc  = 8'(tlrc + TX_IN_DATA);
               next_tst   = T_BYTE;
            end
         T_BYTE, T_LO:
            if (hs && tvar == V_ASCII && tst == T_BYTE)
               next_tst = T_LO;
            else if (hs && !tlast)
               next_tst = T_GET;
            else if (hs && tvar == V_TCP)
            begin
               next_tst = T_IDLE;
               tx_end   = 1'b1;
            end
            else if (hs)
               next_tst = T_CK_A;
         T_CK_A:
            if (hs)
               next_tst = T_CK_B;
         T_CK_B, T_LF:
            if (hs && tvar == V_ASCII && tst == T_CK_B)
               next_tst = T_CR;
            else if (hs)
            begin
               next_tst = T_IDLE;
               tx_end   = 1'b1;
            end
         T_CR:
            if (hs)
               next_tst = T_LF;
         default:
            next_tst = T_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         tst         <= T_IDLE;
         tvar        <= V_RTU;
         tcrc        <= CRC_INIT;
         tlrc        <= '0;
         hold        <= '0;
         tlast       <= 1'b0;
         TX_IN_READY <= 1'b0;
         TX_VALID    <= 1'b0;
         TX_DATA     <= '0;
         DRIVE_EN    <= 1'b0;
      end
      else
      begin
         tst         <= next_tst;
         tvar        <= next_tvar;
         tcrc        <= next_tcrc;
         tlrc        <= next_tlrc;
         hold        <= next_hold;
         tlast       <= next_tlast;
         TX_IN_READY <= next_tst == T_GET;
         TX_VALID    <= !(next_tst inside {T_IDLE, T_GET});
         DRIVE_EN    <= next_tst != T_IDLE;
         case (next_tst)
            T_COLON: TX_DATA <= ASC_COLON;
            T_BYTE:  TX_DATA <= (next_tvar == V_ASCII)
                                ? hex_char(next_hold[7:4]) : next_hold;
            T_LO:    TX_DATA <= hex_char(next_hold[3:0]);
            T_CK_A:  TX_DATA <= (next_tvar == V_ASCII)
                        ? hex_char(4'((8'h00 - next_tlrc) >> 4))
                        : next_tcrc[7:0];
            T_CK_B:  TX_DATA <= (next_tvar == V_ASCII)
                        ? hex_char(4'(8'h00 - next_tlrc))
                        : next_tcrc[15:8];
            T_CR:    TX_DATA <= ASC_CR;
            T_LF:    TX_DATA <= ASC_LF;
            default: TX_DATA <= TX_DATA;
         endcase
      end
   end

   // ****************************************
   // buffer, power and turn taking
   // ****************************************
   always_comb
   begin
      next_buf0 = buf0;
      next_buf1 = buf1;
      next_bcnt = bcnt;
      if (OUT_VALID && OUT_READY)
      begin
         next_buf0 = buf1;
         next_bcnt = 2'(bcnt - 1'b1);
      end
      if (push && next_bcnt == 2'h0)
         next_buf0 = '{first: cnt == 16'h0000 || !in_frame, data: b};
      if (push && next_bcnt == 2'h1)
         next_buf1 = '{first: cnt == 16'h0000 || !in_frame, data: b};
      if (push)
         next_bcnt = 2'(next_bcnt + 1'b1);
      next_enter = 1'b0;
      next_asleep = ASLEEP && !ALWAYS_ON && !got;
      next_idle = idle;
      if (ALWAYS_ON || got || hs)
         next_idle = '0;
      else if (!ASLEEP && idle == SLP_LAST)
      begin
         next_idle   = '0;
         next_asleep = 1'b1;
         next_enter  = 1'b1;
      end
      else if (!ASLEEP)
         next_idle = SLP_W'(idle + 1'b1);
      next_wake = (got && ASLEEP) || (wake_disc && !next_done);
      next_pending = (!MASTER && next_done && next_rpt.good)
                     || (pending && !tx_end);
      next_rwait = (tx_end || !awaiting) ? '0 : RPL_W'(rwait + 1'b1);
      next_awaiting = (MASTER && tx_end) || (awaiting && !next_done
                      && rwait != RPL_LAST);
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         buf0        <= '0;
         buf1        <= '0;
         bcnt        <= '0;
         OUT_VALID   <= 1'b0;
         OUT_BEAT    <= '0;
         RX_READY    <= 1'b0;
         ASLEEP      <= 1'b0;
         SLEEP_ENTER <= 1'b0;
         idle        <= '0;
         wake_disc   <= 1'b0;
         pending     <= 1'b0;
         awaiting    <= 1'b0;
         rwait       <= '0;
         AWAIT_REPLY <= 1'b0;
      end
      else
      begin
         buf0        <= next_buf0;
         buf1        <= next_buf1;
         bcnt        <= next_bcnt;
         OUT_VALID   <= next_bcnt != 2'h0;
         OUT_BEAT    <= next_buf0;
         RX_READY    <= next_bcnt != 2'h2;
         ASLEEP      <= next_asleep;
         SLEEP_ENTER <= next_enter;
         idle        <= next_idle;
         wake_disc   <= next_wake;
         pending     <= next_pending;
         awaiting    <= next_awaiting;
         rwait       <= next_rwait;
         AWAIT_REPLY <= next_awaiting;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_ck_sent;
      hs && tst == T_CK_B && tvar == V_ASCII;
   endsequence
   sequence s_cr_lf;
      TX_VALID && TX_DATA == ASC_CR ##[1:1000] hs && TX_DATA == ASC_LF;
   endsequence
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   AST_SLEEP: assert property (
      !ALWAYS_ON && !got && !hs && !ASLEEP && idle == SLP_LAST
      |=> ASLEEP && SLEEP_ENTER) else $error("no sleep after idle");
   AST_ALWAYS_ON: assert property (
      ALWAYS_ON |=> !ASLEEP) else $error("asleep while always on");
   AST_WAKE: assert property (
      got && ASLEEP |=> wake_disc ##0 (!FRAME_DONE || !FRAME_RPT.good)
      ) else $error("wake packet not discarded");
   AST_GAP: assert property (
      got && in_frame && rvar == V_RTU && sil >= G15 |=> broken)
      else $error("char gap not flagged");
   AST_END: assert property (
      in_frame && rvar == V_RTU && !got && sil == G35 - 1'b1
      |=> FRAME_DONE ##0 !in_frame) else $error("no frame end");
   AST_CRC: assert property (
      FRAME_DONE && rvar == V_RTU && crc != 16'h0000 |-> !FRAME_RPT.good)
      else $error("bad check accepted");
   AST_ASCII: assert property (
      s_ck_sent |=> s_cr_lf) else $error("ASCII trailer missing");
   AST_TCP: assert property (
      tst == T_IDLE && start_ok && !in_frame && LINK_IP
      |=> tvar == V_TCP) else $error("IP link not TCP");
   AST_SLAVE: assert property (
      tst == T_IDLE && start_ok && !in_frame && !LINK_IP && !MASTER
      |=> tvar == V_RTU) else $error("slave not binary");
   AST_DRIVE: assert property (
      TX_VALID |-> DRIVE_EN) else $error("sending without drive");
   AST_WAIT: assert property (
      MASTER && AWAIT_REPLY && tst == T_IDLE |=> tst == T_IDLE)
      else $error("master sent while waiting");
   AST_ADDR: assert property (
      FRAME_DONE && FRAME_RPT.good && !MASTER && !LINK_IP |-> addr_ok)
      else $error("foreign address accepted");
endmodule

/* tb/mb_remote.sv */
/*
 * Far-side UART sink model: takes framed characters from the transmitter.
 * Assumes same-clock byte handshake and a pair enable from the framer.
 */
`timescale 1ns/10ps
module mb_remote
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       drive_en,
   input  wire logic       slow,
   output logic            tx_ready
);
   logic [7:0] got[$];
   logic [1:0] ph = 2'h0;
   // ****************************************
   // accept chars; slow mode stalls 3 of 4
   // ****************************************
   always @(posedge clk)
   begin
      ph <= ph + 2'h1;
      tx_ready <= rstn && (!slow || ph == 2'h3);
      // a char off the pair arrives corrupted
      if (tx_valid && tx_ready)
         got.push_back(drive_en ? tx_data : ~tx_data);
   end
endmodule

/* tb/modbus_serial_link_front_end_bench.sv */
/*
 * Directed bench for the framer front end: slave codes, replies, sleep,
 * master ASCII send. Assumes mb_front and mb_remote compiled before it.
 */
`timescale 1ns/10ps
module modbus_serial_link_front_end_bench;
   import mb_front_pkg::*;
   logic sys_clk = 0, rstn = 0, master = 0, ascii_sel = 0, always_on = 1;
   logic rx_valid = 0, out_ready = 1, tx_in_valid = 0, tx_in_last = 0;
   logic slow = 0, dn = 0, link_ip = 0;
   logic [7:0] rx_data = 8'h00, tx_in_data = 8'h00;
   logic rx_ready, out_valid, frame_done, tx_in_ready, tx_valid, tx_ready;
   logic drive_en, asleep, sleep_enter, await_reply;
   logic [7:0] tx_data;
   beat_t out_beat;
   rpt_t frame_rpt, rpt;
   beat_t outq[$];
   int errors = 0, tests_run = 0, cyc = 0, k;
   mb_front #(.CHAR_CYC(20), .SLEEP_CNT(150), .REPLY_CNT(200)) dut_u (
      .SYS_CLK(sys_clk), .RSTN(rstn), .MASTER(master), .ASCII_SEL(ascii_sel),
      .LINK_IP(link_ip), .ALWAYS_ON(always_on), .SLAVE_ADDR(8'h05),
      .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_READY(rx_ready),
      .OUT_VALID(out_valid), .OUT_BEAT(out_beat), .OUT_READY(out_ready),
      .FRAME_DONE(frame_done), .FRAME_RPT(frame_rpt),
      .TX_IN_VALID(tx_in_valid), .TX_IN_DATA(tx_in_data),
      .TX_IN_LAST(tx_in_last), .TX_IN_READY(tx_in_ready),
      .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready),
      .DRIVE_EN(drive_en), .ASLEEP(asleep), .SLEEP_ENTER(sleep_enter),
      .AWAIT_REPLY(await_reply));
   mb_remote mb_u (.clk(sys_clk), .rstn(rstn), .tx_valid(tx_valid),
      .tx_data(tx_data), .drive_en(drive_en), .slow(slow),
      .tx_ready(tx_ready));
   // ****************************************
   // clock, watchdog, output capture
   // ****************************************
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         end_sim();
      end
      if (out_valid && out_ready) outq.push_back(out_beat);
      if (frame_done) {dn, rpt} = {1'b1, frame_rpt};
   end
   task automatic end_sim();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] crc(input logic [7:0] b[$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (b[i])
      begin
         c ^= {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   // ****************************************
   // bus tasks: receive frame, send body
   // ****************************************
   task automatic rx_frame(input logic [7:0] b[$], input logic [7:0] bad);
      logic [15:0] c;
      c = crc(b);
      b.push_back(c[7:0]);
      b.push_back(c[15:8] ^ bad);
      dn = 1'b0;
      outq = {};
      foreach (b[i])
      begin
         {rx_valid, rx_data} <= {1'b1, b[i]};
         @(posedge sys_clk);
         while (!rx_ready) @(posedge sys_clk);
      end
      rx_valid <= 1'b0;
      for (k = 0; k < 300 && !dn; k++) @(posedge sys_clk);
      chk(dn, 1'b1);
   endtask
   task automatic tx_body(input logic [7:0] b[$]);
      mb_u.got = {};
      foreach (b[i])
      begin
         tx_in_valid <= 1'b1;
         {tx_in_data, tx_in_last} <= {b[i], i == b.size() - 1};
         @(posedge sys_clk);
         while (!tx_in_ready) @(posedge sys_clk);
      end
      tx_in_valid <= 1'b0;
      @(posedge sys_clk);
      for (k = 0; k < 300 && drive_en !== 1'b0; k++) @(posedge sys_clk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_codes();
      logic [7:0] fc[8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                            8'h05, 8'h06, 8'h0F, 8'h10};
      logic [1:0] tb[8] = '{0, 1, 3, 2, 0, 3, 0, 3};
      logic [15:0] c;
      foreach (fc[i])
      begin
         out_ready <= 1'b0;
         fork
            rx_frame('{8'h05, fc[i], 0, 0, 0, 1}, 8'h00);
            begin
               repeat (20) @(posedge sys_clk);
               out_ready <= 1'b1;
            end
         join
         chk(9'(outq.size()), 9'd8);
         chk(outq[0], {1'b1, 8'h05});
         chk({rpt.good, rpt.func_ok, rpt.tbl}, {2'b11, tb[i]});
         slow <= i[0];
         tx_body('{8'h05, fc[i]});
         c = crc('{8'h05, fc[i]});
         chk(9'(mb_u.got.size()), 9'd4);
         chk(mb_u.got[2], c[7:0]);
         chk(mb_u.got[3], c[15:8]);
      end
   endtask
   task automatic t_reject();
      rx_frame('{8'h06, 8'h03, 0, 0, 0, 1}, 8'h00);
      chk(rpt.good, 1'b0);
      rx_frame('{8'h05, 8'h03, 0, 0, 0, 1}, 8'h01);
      chk(rpt.good, 1'b0);
      // a long stall leaves a gap past 1.5 chars
      out_ready <= 1'b0;
      fork
         rx_frame('{8'h05, 8'h03, 0, 0, 0, 1}, 8'h00);
         begin
            repeat (40) @(posedge sys_clk);
            out_ready <= 1'b1;
         end
      join
      chk(rpt.good, 1'b0);
   endtask
   task automatic t_tcp();
      link_ip <= 1'b1;
      rx_frame('{0, 1, 0, 0, 0, 4, 8'h05, 8'h03}, 8'h00);
      chk({rpt.good, rpt.tbl}, 3'b111);
      chk(9'(outq.size()), 9'd10);
      tx_body('{0, 1, 0, 0, 0, 2, 8'h05, 8'h03});
      chk(9'(mb_u.got.size()), 9'd8);
      link_ip <= 1'b0;
   endtask
   task automatic t_sleep();
      always_on <= 1'b0;
      for (k = 0; k < 200 && sleep_enter !== 1'b1; k++) @(posedge sys_clk);
      chk(sleep_enter, 1'b1);
      @(posedge sys_clk);
      chk(asleep, 1'b1);
      rx_frame('{8'h05, 8'h03, 0, 0, 0, 1}, 8'h00);
      chk({rpt.good, 8'(outq.size())}, 9'h000);
      rx_frame('{8'h05, 8'h03, 0, 0, 0, 1}, 8'h00);
      chk(rpt.good, 1'b1);
      tx_body('{8'h05, 8'h03});
      for (k = 0; k < 200 && asleep !== 1'b1; k++) @(posedge sys_clk);
      chk(asleep, 1'b1);
      always_on <= 1'b1;
      repeat (200) @(posedge sys_clk);
      chk(asleep, 1'b0);
   endtask
   task automatic t_master();
      logic [7:0] e[7] = '{ASC_COLON, 8'h30, 8'h31, ASC_F, ASC_F, ASC_CR,
                           ASC_LF};
      {master, ascii_sel} <= 2'b11;
      tx_body('{8'h01});
      foreach (e[i]) chk(mb_u.got[i], e[i]);
      chk(await_reply, 1'b1);
      for (k = 0; k < 260 && await_reply !== 1'b0; k++) @(posedge sys_clk);
      chk(await_reply, 1'b0);
   endtask
   initial
   begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_codes();
      t_reject();
      t_tcp();
      t_sleep();
      t_master();
      end_sim();
   end
endmodule
